/* design/ldq_pkg.sv */
package ldq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the management port
  localparam logic [4:0] OFS_REFLECTOMETRY_CONTROL  = 5'h16;
  localparam logic [4:0] OFS_REFLECTOMETRY_WINDOW   = 5'h17;
  localparam logic [4:0] OFS_REFLECTOMETRY_PEAK_RESULT  = 5'h18;
  localparam logic [4:0] OFS_REFLECTOMETRY_THRESHOLD_RESULT   = 5'h19;
  localparam logic [4:0] OFS_VAR_CTRL  = 5'h1A;
  localparam logic [4:0] OFS_VAR_DATA  = 5'h1B;
  localparam logic [4:0] OFS_LQM_CTRL  = 5'h1D;
  localparam logic [4:0] OFS_LQM_DATA  = 5'h1E;

  ////////////////////////////////////////////////////////////////////////////
  // reflectometry_control fields
  localparam int unsigned TDR_EN_BIT     = 15;
  localparam int unsigned TDR_100_BIT    = 14;
  localparam int unsigned TDR_TXPAIR_BIT = 13;
  localparam int unsigned TDR_RXPAIR_BIT = 12;
  localparam int unsigned TDR_SEND_BIT   = 11;
  localparam int unsigned TDR_WID_MSB    = 10;
  localparam int unsigned TDR_WID_LSB    = 8;
  localparam int unsigned TDR_MIN_BIT    = 7;
  localparam int unsigned REFLECTOMETRY_THRESHOLD_RESULT_MSB    = 6;
  localparam logic [15:0] REFLECTOMETRY_CONTROL_RST   = 16'h0000;
  localparam logic [15:0] REFLECTOMETRY_WINDOW_RST    = 16'h00FF;
  localparam int unsigned WIN_START_LSB  = 8;
  localparam logic [7:0]  TDR_LAST_TICK  = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // variance_control fields
  localparam int unsigned VAR_SEL_MSB    = 1;
  localparam int unsigned VAR_SEL_LSB    = 0;
  localparam int unsigned VAR_RDY_BIT    = 15;
  localparam logic [15:0] VAR_CTRL_RST   = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // quality monitor fields
  localparam int unsigned LQM_EN_BIT     = 15;
  localparam int unsigned LQ_N_PARAM     = 5;
  localparam int unsigned LQ_N_THR       = 10;
  localparam int unsigned LQD_SAMPLE_BIT = 13;
  localparam int unsigned LQD_WRITE_BIT  = 12;
  localparam int unsigned LQD_SEL_MSB    = 11;
  localparam int unsigned LQD_SEL_LSB    = 9;
  localparam int unsigned LQD_HI_BIT     = 8;
  localparam logic [3:0]  LQ_N_THR_IDX   = 4'hA;

  localparam logic [2:0] PAR_EQ   = 3'h0;
  localparam logic [2:0] PAR_GAIN = 3'h1;
  localparam logic [2:0] PAR_BLW  = 3'h2;
  localparam logic [2:0] PAR_LONG_TERM_FREQUENCY_OFFSET = 3'h3;
  localparam logic [2:0] PAR_FC   = 3'h4;

  localparam logic [7:0] SMIN = 8'h80;
  localparam logic [7:0] SMAX = 8'h7F;
  localparam logic [7:0] UMIN = 8'h00;
  localparam logic [7:0] UMAX = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned NS_PER_MS       = 1000000;
  localparam int unsigned VAR_STEP_MS     = 2;
  localparam int unsigned VAR_STEP_CYCLES =
    VAR_STEP_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_SHORT_NS  = 50;
  localparam int unsigned PULSE_LONG_NS   = 100;
  localparam logic [2:0]  PULSE_SHORT_CYC =
    3'((PULSE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0]  PULSE_LONG_CYC  =
    3'((PULSE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0]  LONG_SEL_MIN    = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [7:0] eq_c1;
    logic [7:0] gain;
    logic [7:0] blw;
    logic [7:0] long_term_frequency_offset;
    logic [7:0] fc;
  } ldq_dsp_t;

  typedef struct packed {
    logic ten_en;
    logic hundred_en;
    logic positive;
    logic on_rx_pair;
  } ldq_drive_t;

  typedef struct packed {
    logic [7:0] peak_time;
    logic [7:0] peak_val;
    logic [7:0] cross_time;
    logic [7:0] cross_val;
  } ldq_tdr_res_t;

  typedef enum logic [0:0] {
    TDR_IDLE = 1'b0,
    TDR_RUN  = 1'b1
  } ldq_tdr_state_t;

endpackage

/* design/ldq_tdr_tracker.sv */
`timescale 1ns/1ps
module ldq_tdr_tracker
  import ldq_pkg::*;
(
  input  wire logic         sys_clk,   // clock
  input  wire logic         arst_n,    // async reset
  input  wire logic         clk_en,    // clock enable
  input  wire logic         clear,     // new run
  input  wire logic         sample_ok, // sample inside window
  input  wire logic [7:0]   sample,    // adc sample, signed
  input  wire logic [7:0]   timer,     // ticks since pulse
  input  wire logic         min_mode,  // search negative
  input  wire logic [6:0]   thr_mag,   // crossing magnitude
  output ldq_tdr_res_t      result     // peak and crossing
);

  ldq_tdr_res_t res;
  ldq_tdr_res_t next_res;
  logic         have_peak;
  logic         next_have_peak;
  logic         crossed;
  logic         next_crossed;
  logic         better;
  logic         beyond;
  logic signed [7:0] thr_s;

  assign result = res;

  always_comb begin
    thr_s          = $signed({1'b0, thr_mag});
    next_res       = res;
    next_have_peak = have_peak;
    next_crossed   = crossed;
    better = min_mode ? ($signed(sample) < $signed(res.peak_val))
                      : ($signed(sample) > $signed(res.peak_val));
    beyond = min_mode ? ($signed(sample) < -thr_s)
                      : ($signed(sample) > thr_s);
    if (clear) begin
      next_res       = '0;
      next_have_peak = 1'b0;
      next_crossed   = 1'b0;
    end else if (sample_ok) begin
      if (!have_peak || better) begin
        next_res.peak_val  = sample;
        next_res.peak_time = timer;
        next_have_peak     = 1'b1;
      end
      if (!crossed && beyond) begin
        next_res.cross_val  = sample;
        next_res.cross_time = timer;
        next_crossed        = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      res       <= '0;
      have_peak <= 1'b0;
      crossed   <= 1'b0;
    end else if (clk_en) begin
      res       <= next_res;
      have_peak <= next_have_peak;
      crossed   <= next_crossed;
    end
  end

endmodule

/* design/ldq_link_diag.sv */
`timescale 1ns/1ps
// Summary of operation
// - variance accumulates over 2/4/6/8 ms periods
// - 32-bit sum read as two halves
// - monitor compares only while enable set
// - separate high and low warning per parameter
// - warn only strictly beyond threshold
// - thresholds reset to parameter min/max
// - four params signed, gain unsigned
// - sample bit captures adapted value for readback
// - three-bit select, code 010 is wander
// - thresholds written and read indirectly
// - enable bit hands drivers to reflectometry
// - send bit emits pulse, starts timer
// - bit 14 selects 10 Mb or 100 Mb
// - width 0..7 clocks at 100 Mb (10 Mb: 3 or 5 clocks), 100 Mb alternates polarity
// - zero width: no pulse, monitor runs
// - bit 13 chooses pulse pair
// - bit 12 chooses sampled pair
// - bit 7 searches minimum instead of maximum
// - sample only from start to stop tick
// - track peak and first crossing times
// - peak and crossing in separate registers
module ldq_link_diag
  import ldq_pkg::*;
#(
  parameter int unsigned VAR_STEP_CYC = VAR_STEP_CYCLES  // cycles per 2 ms
)(
  input  wire logic        sys_clk,      // 50 MHz clock
  input  wire logic        arst_n,       // async reset
  input  wire logic        clk_en,       // freezes all state when low
  input  wire logic [4:0]  reg_addr,     // register address
  input  wire logic        reg_wr,       // write strobe
  input  wire logic        reg_rd,       // read strobe
  input  wire logic [15:0] reg_wdata,    // write data
  output logic      [15:0] reg_rdata,    // read data, next cycle
  input  ldq_dsp_t         dsp,          // adapted dsp values
  input  wire logic [15:0] err_sq,       // squared error sample
  input  wire logic        err_valid,    // err_sq valid
  input  wire logic [7:0]  adc_tx_pair,  // adc, transmit pair
  input  wire logic [7:0]  adc_rx_pair,  // adc, receive pair
  output ldq_drive_t       tdr_drive,    // pulse drive to line
  output logic             tdr_owns,     // drivers owned by tdr
  output logic             lq_warning    // any warning latched
);

  ////////////////////////////////////////////////////////////////////////////
  // functions
  function automatic logic [7:0] param_value(ldq_dsp_t d, logic [2:0] s);
    case (s)
      PAR_EQ:   param_value = d.eq_c1;
      PAR_GAIN: param_value = d.gain;
      PAR_BLW:  param_value = d.blw;
      PAR_LONG_TERM_FREQUENCY_OFFSET: param_value = d.long_term_frequency_offset;
      PAR_FC:   param_value = d.fc;
      default:  param_value = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] thr_reset(logic [3:0] idx);
    logic gain;
    gain = (idx[3:1] == PAR_GAIN);
    if (idx[0])
      thr_reset = gain ? UMAX : SMAX;
    else
      thr_reset = gain ? UMIN : SMIN;
  endfunction

  function automatic logic beyond(logic [7:0] v, logic [7:0] t,
                                  logic sgn, logic hi);
    if (sgn)
      beyond = hi ? ($signed(v) > $signed(t))
                  : ($signed(v) < $signed(t));
    else
      beyond = hi ? (v > t) : (v < t);
  endfunction

  function automatic logic [2:0] pulse_cycles(logic m100, logic [2:0] w);
    if (w == 3'h0)
      pulse_cycles = 3'h0;
    else if (m100)
      pulse_cycles = w;
    else
      pulse_cycles = (w >= LONG_SEL_MIN) ? PULSE_LONG_CYC
                                         : PULSE_SHORT_CYC;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // access decode
  logic wr_reflectometry_control, wr_reflectometry_window, wr_var_ctrl, wr_lqm_ctrl, wr_lqm_data;
  logic rd_var_data, rd_lqm_ctrl;

  assign wr_reflectometry_control = reg_wr && (reg_addr == OFS_REFLECTOMETRY_CONTROL);
  assign wr_reflectometry_window  = reg_wr && (reg_addr == OFS_REFLECTOMETRY_WINDOW);
  assign wr_var_ctrl = reg_wr && (reg_addr == OFS_VAR_CTRL);
  assign wr_lqm_ctrl = reg_wr && (reg_addr == OFS_LQM_CTRL);
  assign wr_lqm_data = reg_wr && (reg_addr == OFS_LQM_DATA);
  assign rd_var_data = reg_rd && (reg_addr == OFS_VAR_DATA);
  assign rd_lqm_ctrl = reg_rd && (reg_addr == OFS_LQM_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // variance estimator
  logic [15:0] var_ctrl, next_var_ctrl;
  logic [31:0] var_acc, next_var_acc;
  logic [31:0] var_cnt, next_var_cnt;
  logic [31:0] var_sum, next_var_sum;
  logic [15:0] var_hi, next_var_hi;
  logic        var_half, next_var_half;
  logic        var_rdy, next_var_rdy;
  logic [31:0] var_period;
  logic [31:0] var_term;
  logic        var_end;

  always_comb begin
    var_period = VAR_STEP_CYC *
                 (32'(var_ctrl[VAR_SEL_MSB:VAR_SEL_LSB]) + 32'h1);
    var_term   = err_valid ? {16'h0000, err_sq} : 32'h0;
    var_end    = (var_cnt == var_period - 32'h1);
    next_var_ctrl = var_ctrl;
    next_var_acc  = var_acc;
    next_var_cnt  = var_cnt;
    next_var_sum  = var_sum;
    next_var_hi   = var_hi;
    next_var_half = var_half;
    next_var_rdy  = var_rdy;
    if (rd_var_data) begin
      if (!var_half) begin
        next_var_hi   = var_sum[31:16];
        next_var_half = 1'b1;
      end else begin
        next_var_half = 1'b0;
        next_var_rdy  = 1'b0;
      end
    end
    if (wr_var_ctrl) begin
      next_var_ctrl = reg_wdata;
      next_var_acc  = 32'h0;
      next_var_cnt  = 32'h0;
      next_var_half = 1'b0;
    end else if (var_end) begin
      next_var_sum = var_acc + var_term;
      next_var_acc = 32'h0;
      next_var_cnt = 32'h0;
      next_var_rdy = 1'b1;
    end else begin
      next_var_acc = var_acc + var_term;
      next_var_cnt = var_cnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      var_ctrl <= VAR_CTRL_RST;
      var_acc  <= 32'h0;
      var_cnt  <= 32'h0;
      var_sum  <= 32'h0;
      var_hi   <= 16'h0000;
      var_half <= 1'b0;
      var_rdy  <= 1'b0;
    end else if (clk_en) begin
      var_ctrl <= next_var_ctrl;
      var_acc  <= next_var_acc;
      var_cnt  <= next_var_cnt;
      var_sum  <= next_var_sum;
      var_hi   <= next_var_hi;
      var_half <= next_var_half;
      var_rdy  <= next_var_rdy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link quality monitor
  logic        lqm_en, next_lqm_en;
  logic [9:0]  warn, next_warn;
  logic [9:0]  raise;
  logic [7:0]  thr_q [LQ_N_THR];
  logic [7:0]  next_thr [LQ_N_THR];
  logic [3:0]  lqd_addr, next_lqd_addr;
  logic [7:0]  lqd_sample, next_lqd_sample;
  logic        lqd_show, next_lqd_show;
  logic [3:0]  wr_idx;
  logic [2:0]  wr_sel;
  logic [7:0]  thr_read;

  assign wr_sel = reg_wdata[LQD_SEL_MSB:LQD_SEL_LSB];
  assign wr_idx = reg_wdata[LQD_SEL_MSB:LQD_HI_BIT];

  always_comb begin
    raise = 10'h000;
    for (int k = 0; k < LQ_N_PARAM; k++) begin
      if (lqm_en) begin
        raise[2*k]   = beyond(param_value(dsp, 3'(k)), thr_q[2*k],
                              3'(k) != PAR_GAIN, 1'b0);
        raise[2*k+1] = beyond(param_value(dsp, 3'(k)), thr_q[2*k+1],
                              3'(k) != PAR_GAIN, 1'b1);
      end
    end
    next_warn = (rd_lqm_ctrl ? 10'h000 : warn) | raise;
    next_lqm_en     = wr_lqm_ctrl ? reg_wdata[LQM_EN_BIT] : lqm_en;
    next_lqd_addr   = lqd_addr;
    next_lqd_sample = lqd_sample;
    next_lqd_show   = lqd_show;
    for (int i = 0; i < LQ_N_THR; i++) begin
      next_thr[i] = thr_q[i];
    end
    if (wr_lqm_data) begin
      next_lqd_addr = wr_idx;
      next_lqd_show = reg_wdata[LQD_SAMPLE_BIT];
      if (reg_wdata[LQD_SAMPLE_BIT]) begin
        next_lqd_sample = param_value(dsp, wr_sel);
      end
      if (reg_wdata[LQD_WRITE_BIT] && (wr_idx < LQ_N_THR_IDX)) begin
        next_thr[wr_idx] = reg_wdata[7:0];
      end
    end
    thr_read = (lqd_addr < LQ_N_THR_IDX) ? thr_q[lqd_addr] : 8'h00;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lqm_en     <= 1'b0;
      warn       <= 10'h000;
      lqd_addr   <= 4'h0;
      lqd_sample <= 8'h00;
      lqd_show   <= 1'b0;
      for (int i = 0; i < LQ_N_THR; i++) begin
        thr_q[i] <= thr_reset(4'(i));
      end
    end else if (clk_en) begin
      lqm_en     <= next_lqm_en;
      warn       <= next_warn;
      lqd_addr   <= next_lqd_addr;
      lqd_sample <= next_lqd_sample;
      lqd_show   <= next_lqd_show;
      for (int i = 0; i < LQ_N_THR; i++) begin
        thr_q[i] <= next_thr[i];
      end
    end
  end

  assign lq_warning = |warn;

  ////////////////////////////////////////////////////////////////////////////
  // reflectometry sequencer
  ldq_tdr_state_t tdr_state, next_tdr_state;
  logic [15:0]    reflectometry_control, next_reflectometry_control;
  logic [15:0]    reflectometry_window, next_reflectometry_window;
  logic [7:0]     tdr_timer, next_tdr_timer;
  logic [2:0]     pulse_left, next_pulse_left;
  logic           pol, next_pol;
  ldq_drive_t     drive, next_drive;
  logic           tdr_start;
  logic           sample_ok;
  logic [7:0]     mon_sample;
  ldq_tdr_res_t   tdr_res;

  assign tdr_start = wr_reflectometry_control && reg_wdata[TDR_SEND_BIT]
                     && reg_wdata[TDR_EN_BIT];

  always_comb begin
    next_tdr_state  = tdr_state;
    next_tdr_timer  = tdr_timer;
    next_pulse_left = pulse_left;
    next_pol        = pol;
    next_reflectometry_control   = reflectometry_control;
    next_reflectometry_window    = wr_reflectometry_window ? reg_wdata : reflectometry_window;
    if (wr_reflectometry_control) begin
      next_reflectometry_control = reg_wdata;
      next_reflectometry_control[TDR_SEND_BIT] = 1'b0;
    end
    case (tdr_state)
      TDR_IDLE: begin
        if (tdr_start) begin
          next_tdr_state  = TDR_RUN;
          next_tdr_timer  = 8'h00;
          next_pulse_left = pulse_cycles(reg_wdata[TDR_100_BIT],
                              reg_wdata[TDR_WID_MSB:TDR_WID_LSB]);
          if (reg_wdata[TDR_100_BIT] &&
              reg_wdata[TDR_WID_MSB:TDR_WID_LSB] != 3'h0) begin
            next_pol = ~pol;
          end
        end
      end
      TDR_RUN: begin
        next_tdr_timer = tdr_timer + 8'h01;
        if (pulse_left != 3'h0) begin
          next_pulse_left = pulse_left - 3'h1;
        end
        if (tdr_timer == TDR_LAST_TICK) begin
          next_tdr_state  = TDR_IDLE;
          next_pulse_left = 3'h0;
        end
      end
      default: begin
        next_tdr_state = TDR_IDLE;
      end
    endcase
    if (!next_reflectometry_control[TDR_EN_BIT]) begin
      next_tdr_state  = TDR_IDLE;
      next_pulse_left = 3'h0;
    end
    next_drive.ten_en     = (next_pulse_left != 3'h0)
                            && !next_reflectometry_control[TDR_100_BIT];
    next_drive.hundred_en = (next_pulse_left != 3'h0)
                            && next_reflectometry_control[TDR_100_BIT];
    next_drive.positive   = next_reflectometry_control[TDR_100_BIT] ? next_pol
                                                       : 1'b1;
    next_drive.on_rx_pair = next_reflectometry_control[TDR_TXPAIR_BIT];
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tdr_state  <= TDR_IDLE;
      reflectometry_control   <= REFLECTOMETRY_CONTROL_RST;
      reflectometry_window    <= REFLECTOMETRY_WINDOW_RST;
      tdr_timer  <= 8'h00;
      pulse_left <= 3'h0;
      pol        <= 1'b0;
      drive      <= '0;
    end else if (clk_en) begin
      tdr_state  <= next_tdr_state;
      reflectometry_control   <= next_reflectometry_control;
      reflectometry_window    <= next_reflectometry_window;
      tdr_timer  <= next_tdr_timer;
      pulse_left <= next_pulse_left;
      pol        <= next_pol;
      drive      <= next_drive;
    end
  end

  assign tdr_drive = drive;
  assign tdr_owns  = reflectometry_control[TDR_EN_BIT];
  assign mon_sample = reflectometry_control[TDR_RXPAIR_BIT] ? adc_rx_pair
                                               : adc_tx_pair;
  assign sample_ok = (tdr_state == TDR_RUN)
                     && (tdr_timer >= reflectometry_window[15:WIN_START_LSB])
                     && (tdr_timer <= reflectometry_window[WIN_START_LSB-1:0]);

  ldq_tdr_tracker u_tracker (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .clear     (tdr_start && (tdr_state == TDR_IDLE)),
    .sample_ok (sample_ok),
    .sample    (mon_sample),
    .timer     (tdr_timer),
    .min_mode  (reflectometry_control[TDR_MIN_BIT]),
    .thr_mag   (reflectometry_control[REFLECTOMETRY_THRESHOLD_RESULT_MSB:0]),
    .result    (tdr_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data
  logic [15:0] rdata, next_rdata;

  always_comb begin
    next_rdata = rdata;
    if (reg_rd) begin
      case (reg_addr)
        OFS_REFLECTOMETRY_CONTROL: begin
          next_rdata = reflectometry_control;
          next_rdata[TDR_SEND_BIT] = (tdr_state == TDR_RUN);
        end
        OFS_REFLECTOMETRY_WINDOW:  next_rdata = reflectometry_window;
        OFS_REFLECTOMETRY_PEAK_RESULT: next_rdata = {tdr_res.peak_time,
                                    tdr_res.peak_val};
        OFS_REFLECTOMETRY_THRESHOLD_RESULT:  next_rdata = {tdr_res.cross_time,
                                    tdr_res.cross_val};
        OFS_VAR_CTRL: begin
          next_rdata = var_ctrl;
          next_rdata[VAR_RDY_BIT] = var_rdy;
        end
        OFS_VAR_DATA: next_rdata = var_half ? var_hi
                                            : var_sum[15:0];
        OFS_LQM_CTRL: next_rdata = {lqm_en, 5'h00, warn};
        OFS_LQM_DATA: next_rdata = {4'h0, lqd_addr,
                                    lqd_show ? lqd_sample
                                             : thr_read};
        default:      next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      rdata <= next_rdata;
    end
  end

  assign reg_rdata = rdata;

endmodule

/* tb/ldq_link_diag_chk.sv */
`timescale 1ns/1ps
module ldq_chk
  import ldq_pkg::*;
(
  input wire logic        sys_clk,    // clock
  input wire logic        arst_n,     // reset
  input wire logic        clk_en,     // enable
  input wire logic [4:0]  reg_addr,   // address
  input wire logic        reg_wr,     // write
  input wire logic        reg_rd,     // read
  input wire logic [15:0] reg_wdata,  // wdata
  input wire logic [15:0] reg_rdata,  // rdata
  input ldq_drive_t       tdr_drive,  // drive
  input wire logic        tdr_owns,   // owned
  input wire logic        lq_warning  // warning
);
  logic [2:0] s_h;
  logic [2:0] e_h;
  logic       own;
  logic       m_en;
  logic       h_q;
  logic       l_pos;
  wire        w = reg_wr && clk_en;
  // send history, enable mirrors, last 100 Mb polarity
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {s_h, e_h, own, m_en, h_q, l_pos} <= '0;
    end else begin
      s_h <= {s_h[1:0], w && reg_addr == OFS_REFLECTOMETRY_CONTROL && reg_wdata[15]
              && reg_wdata[11] && reg_wdata[10:8] != 3'h0};
      e_h <= {e_h[1:0], m_en};
      h_q <= tdr_drive.hundred_en;
      if (w && reg_addr == OFS_REFLECTOMETRY_CONTROL) own <= reg_wdata[15];
      if (w && reg_addr == OFS_LQM_CTRL) m_en <= reg_wdata[15];
      if (tdr_drive.hundred_en && !h_q) l_pos <= tdr_drive.positive;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_owns_follow: assert property (
    $changed(own) |-> ##[0:1] tdr_owns == own) else $error("owns lag");
  a_idle_quiet: assert property (
    !tdr_owns ##1 !tdr_owns |-> !tdr_drive.ten_en && !tdr_drive.hundred_en)
    else $error("drive while not owned");
  a_ten_width: assert property (
    $rose(tdr_drive.ten_en) |-> tdr_drive.ten_en [*3] ##1 (!tdr_drive.ten_en
    or (tdr_drive.ten_en [*2] ##1 !tdr_drive.ten_en)))
    else $error("10 Mb pulse width");
  a_hund_width: assert property (
    $rose(tdr_drive.hundred_en) |-> ##[1:7] !tdr_drive.hundred_en)
    else $error("100 Mb pulse too long");
  a_pol_alt: assert property (
    $rose(tdr_drive.hundred_en) |-> tdr_drive.positive != l_pos)
    else $error("polarity not alternating");
  a_send_cause: assert property (
    $rose(tdr_drive.ten_en || tdr_drive.hundred_en) |-> |s_h)
    else $error("pulse without send");
  a_warn_enabled: assert property (
    $rose(lq_warning) |-> |{e_h, m_en}) else $error("warning while off");
  a_warn_read: assert property (
    w == 1'b0 && reg_rd && clk_en && reg_addr == OFS_LQM_CTRL && lq_warning
    && !$past(reg_rd) |=> reg_rdata[9:0] != 10'h000)
    else $error("warning lost before read");
  c_ten: cover property ($rose(tdr_drive.ten_en));
  c_hund: cover property ($rose(tdr_drive.hundred_en));
  c_warn: cover property ($rose(lq_warning));
endmodule
bind ldq_link_diag ldq_chk i_chk (.sys_clk, .arst_n, .clk_en, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .tdr_drive, .tdr_owns,
  .lq_warning);

/* tb/ldq_cable.sv */
`timescale 1ns/1ps
module ldq_cable
  import ldq_pkg::*;
(
  input wire logic   sys_clk,     // clock
  input wire logic   arst_n,      // reset
  input ldq_drive_t  drive,       // pulse drive
  output logic [7:0] adc_tx_pair, // tx pair sample
  output logic [7:0] adc_rx_pair  // rx pair sample
);
  localparam logic [7:0] DLY = 8'h28;  // round trip in ticks
  logic [7:0] cnt;
  logic [7:0] echo;
  logic [7:0] smp;
  logic       on_q;
  wire        on = drive.ten_en || drive.hundred_en;
  // ticks since pulse start, parked at the top
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= 8'hFF;
      on_q <= 1'b0;
    end else begin
      on_q <= on;
      cnt  <= (on && !on_q) ? 8'h01 : (cnt == 8'hFF) ? cnt : cnt + 8'h01;
    end
  end
  // reflection follows pulse sign, only on the driven pair
  always_comb begin
    echo = (cnt == DLY) ? 8'h50 : (cnt == DLY - 8'h01) ? 8'h30 : 8'h00;
    if (on) echo = 8'h70;
    smp = drive.positive ? echo : 8'h00 - echo;
    adc_tx_pair = drive.on_rx_pair ? 8'h00 : smp;
    adc_rx_pair = drive.on_rx_pair ? smp : 8'h00;
  end
endmodule

/* tb/ldq_link_diag_tb.sv */
`timescale 1ns/1ps
module ldq_link_diag_tb
  import ldq_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        clk_en = 1'b1;
  logic        err_valid = 1'b1;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] err_sq = 16'h8000;
  logic [15:0] reg_rdata;
  ldq_dsp_t    dsp = {8'h10, 8'h40, 8'h35, 8'hF0, 8'h05};
  logic [7:0]  adc_tx, adc_rx;
  ldq_drive_t  drive;
  logic        owns, warn;
  int          mismatches = 0;
  int          n_tests = 0;
  logic [15:0] tc [7] = '{16'h8B20, 16'hCB20, 16'hCBA0, 16'hEB20,
                          16'hBB20, 16'h8B20, 16'h8820};
  logic [15:0] tw [7] = '{16'h10FF, 16'h10FF, 16'h10FF, 16'h10FF,
                          16'h10FF, 16'h1027, 16'h10FF};
  logic [15:0] tp [7] = '{16'h2850, 16'h2850, 16'h28B0, 16'h1000,
                          16'h2850, 16'h2730, 16'h1000};
  logic [15:0] tt [7] = '{16'h2730, 16'h2730, 16'h27D0, 16'h0000,
                          16'h2730, 16'h2730, 16'h0000};
  always #10 sys_clk = ~sys_clk;
  ldq_link_diag #(.VAR_STEP_CYC(20)) i_dut (.sys_clk, .arst_n,
    .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .dsp, .err_sq, .err_valid, .adc_tx_pair(adc_tx), .adc_rx_pair(adc_rx),
    .tdr_drive(drive), .tdr_owns(owns), .lq_warning(warn));
  ldq_cable i_cable (.sys_clk, .arst_n, .drive, .adc_tx_pair(adc_tx),
    .adc_rx_pair(adc_rx));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask
  task automatic rc(input string nm, input logic [4:0] a, logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(nm, v, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    logic [15:0] v;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    rc("reflectometry_control", OFS_REFLECTOMETRY_CONTROL, 16'h0000);
    rc("reflectometry_window", OFS_REFLECTOMETRY_WINDOW, 16'h00FF);
    clk_en = 1'b0;
    wr(OFS_REFLECTOMETRY_WINDOW, 16'h1234);
    clk_en = 1'b1;
    rc("win_frozen", OFS_REFLECTOMETRY_WINDOW, 16'h00FF);
    wr(OFS_LQM_DATA, 16'h0300);
    rc("gain_hi", OFS_LQM_DATA, 16'h03FF);
    wr(OFS_LQM_DATA, 16'h0000);
    rc("eq_lo", OFS_LQM_DATA, 16'h0080);
    wr(OFS_LQM_DATA, 16'h2400);
    rc("blw_now", OFS_LQM_DATA, 16'h0435);
    wr(OFS_LQM_DATA, 16'h1535);
    wr(OFS_LQM_CTRL, 16'h8000);
    cyc(5);
    rc("lqm_equal", OFS_LQM_CTRL, 16'h8000);
    dsp.blw = 8'h36;
    cyc(3);
    dsp.blw = 8'h35;
    cyc(5);
    chk("warn_pin", {15'h0000, warn}, 16'h0001);
    rc("lqm_high", OFS_LQM_CTRL, 16'h8020);
    rc("lqm_clear", OFS_LQM_CTRL, 16'h8000);
    wr(OFS_LQM_CTRL, 16'h0000);
    dsp.blw = 8'h36;
    cyc(5);
    rc("lqm_off", OFS_LQM_CTRL, 16'h0000);
    chk("warn_off", {15'h0000, warn}, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_VAR_CTRL, 16'(s));
      v = 16'h0000;
      for (int k = 0; k < 100 && v[15] !== 1'b1; k++) rd(OFS_VAR_CTRL, v);
      chk("var_ready", v, 16'h8000 | 16'(s));
      rc("var_low", OFS_VAR_DATA, 16'h0000);
      rc("var_high", OFS_VAR_DATA, 16'(s + 1) * 16'h000A);
    end
    foreach (tc[i]) begin
      wr(OFS_REFLECTOMETRY_WINDOW, tw[i]);
      wr(OFS_REFLECTOMETRY_CONTROL, tc[i]);
      cyc(300);
      rc("peak", OFS_REFLECTOMETRY_PEAK_RESULT, tp[i]);
      rc("cross", OFS_REFLECTOMETRY_THRESHOLD_RESULT, tt[i]);
    end
    chk("owns_on", {15'h0000, owns}, 16'h0001);
    wr(OFS_REFLECTOMETRY_CONTROL, 16'h0000);
    cyc(2);
    chk("owns_off", {15'h0000, owns}, 16'h0000);
    end_of_test();
  end
endmodule
